/* File: include/fsi_defs.svh */
`ifndef FSI_DEFS_SVH
`define FSI_DEFS_SVH

// Register addresses on the parallel control port
`define FSI_ALARM_STATUS_ADDR 8'h06
`define FSI_TIMING_STATUS_ADDR 8'h07
`define FSI_ALARM_MASK_ADDR 8'h16
`define FSI_TIMING_MASK_ADDR 8'h17

// Bit positions in timing_event_status and timing_interrupt_mask
`define FSI_BIT_RX_MF 7
`define FSI_BIT_RX_AF 6
`define FSI_BIT_TX_MF 5
`define FSI_BIT_SEC 4
`define FSI_BIT_TX_AF 3
`define FSI_BIT_TX_CLK_LOST 2
`define FSI_BIT_RX_CRC_MF 1
`define FSI_BIT_TX_SLIP 0
// Bit position in alarm_status and alarm_interrupt_mask
`define FSI_BIT_RX_SLIP 4

// Reset values
`define FSI_MASK_RESET 8'h00
`define FSI_STATUS_RESET 8'h00

// Timing
`define FSI_CLK_MHZ 40
`define FSI_CHANNEL_TIME_NS 3900
`define FSI_FAST_TIMER_US 62500
`define FSI_CRC_MF_US 2000
`define FSI_FAST_PER_SECOND 16
`define FSI_LOST_CYCLES ((`FSI_CHANNEL_TIME_NS * `FSI_CLK_MHZ) / 1000)
`define FSI_FAST_CYCLES (`FSI_FAST_TIMER_US * `FSI_CLK_MHZ)
`define FSI_CRC_MF_CYCLES (`FSI_CRC_MF_US * `FSI_CLK_MHZ)

`endif

/* File: include/fsi_pkg.sv */
package fsi_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fsi_bus_s;

  typedef struct packed {
    logic rx_mf;
    logic rx_af;
    logic tx_mf;
    logic tx_af;
    logic rx_crc_mf;
    logic tx_slip;
  } fsi_events_s;

  typedef struct packed {
    logic [7:0] timing_status;
    logic [7:0] alarm_status;
    logic [7:0] alarm_mask;
    logic [7:0] timing_mask;
    logic [7:0] rdata;
    logic [1:0] tx_line_clock_sync;
    logic tx_line_clock_prev;
    logic [7:0] lost_cnt;
    logic [3:0] fast_cnt;
    logic irq;
  } fsi_state_s;

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } fsi_tick_state_s;

endpackage

/* File: rtl/fsi_period_tick.sv */
`timescale 1ns/1ps
module fsi_period_tick
  import fsi_pkg::*;
#(
  parameter int unsigned PERIOD = 80000
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Control and event
  input wire logic restart_i,
  output logic tick_o
);

  localparam logic [31:0] LAST = 32'(PERIOD - 1);

  fsi_tick_state_s s;
  fsi_tick_state_s next_s;

  if (PERIOD < 2) begin : g_bad_period
    $error("fsi_period_tick: PERIOD must be at least 2");
  end

  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    if (restart_i)
    begin
      next_s.cnt = 32'h0;
    end
    else if (s.cnt == LAST)
    begin
      next_s.cnt = 32'h0;
      next_s.tick = 1'b1;
    end
    else
    begin
      next_s.cnt = s.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign tick_o = s.tick;

endmodule // fsi_period_tick

/* File: rtl/fsi_status_irq.sv */
// Operation
// RULE1: Each alarm_interrupt_mask bit lets the same alarm_status bit drive the interrupt when one and blocks it when zero, rx slip at bit 4.
// RULE2: Each timing_interrupt_mask bit lets the same timing_event_status bit drive the interrupt when one, clock-loss gate at bit 2.
// RULE3: Bit 6 is set at each receive align frame start, every 250 us, telling the host the spare bits are captured.
// RULE4: Bit 2 is set once the transmit line clock has not toggled for one channel time of about 3.9 us.
// RULE5: Bit 1 is set at each receive CRC4 multiframe boundary while CRC4 framing is on.
// RULE6: With CRC4 framing off, bit 1 is still set every 2 ms on a free-running boundary.
// RULE7: Bit 0 is set whenever the transmit elastic store repeats or deletes a frame.
// RULE8: Bit 4 marks error counter updates, once a second with control bit 7 clear and every 62.5 ms with it set.
// RULE9: Bit 4 of alarm_status is set whenever the receive elastic store repeats or deletes a frame.
// RULE10: Bits 7 and 5 are set at receive and transmit multiframe boundaries and bit 3 at each transmit align frame.
`timescale 1ns/1ps
`include "fsi_defs.svh"
module fsi_status_irq
  import fsi_pkg::*;
#(
  parameter int unsigned FAST_CYCLES = `FSI_FAST_CYCLES,
  parameter int unsigned CRC_MF_CYCLES = `FSI_CRC_MF_CYCLES
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Parallel control port, same clock
  input wire fsi_bus_s bus_i,
  output logic [7:0] rdata_o,
  // Framer events, one-cycle pulses
  input wire fsi_events_s ev_i,
  input wire logic [7:0] alarm_event_i,
  // Configuration
  input wire logic crc4_enable_i,
  input wire logic common_control_two_fast_i,
  // Transmit line clock pin
  input wire logic tx_line_clock_i,
  // Interrupt and counter update mark
  output logic int_o,
  output logic counter_update_o
);

  localparam logic [7:0] LOST_LAST = 8'(`FSI_LOST_CYCLES - 1);
  localparam logic [3:0] FAST_LAST = 4'(`FSI_FAST_PER_SECOND - 1);

  if (`FSI_LOST_CYCLES < 2 || `FSI_LOST_CYCLES > 255) begin : g_bad_lost
    $error("fsi_status_irq: channel time count out of range");
  end

  fsi_state_s s;
  fsi_state_s next_s;
  logic fast_tick;
  logic free_mf_tick;
  logic tx_line_clock_edge;
  logic clk_lost;
  logic sec_evt;
  logic crc_evt;
  logic rd_alarm;
  logic rd_timing;
  logic [7:0] timing_set;

  fsi_period_tick #(
    .PERIOD(FAST_CYCLES)
  ) u_fast_tick (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .restart_i(1'b0),
    .tick_o(fast_tick)
  );

  // Free boundary, held at zero while crc4_enable_i is high
  fsi_period_tick #(
    .PERIOD(CRC_MF_CYCLES)
  ) u_free_mf_tick (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .restart_i(crc4_enable_i),
    .tick_o(free_mf_tick)
  );

  always_comb
  begin
    tx_line_clock_edge = s.tx_line_clock_sync[1] ^ s.tx_line_clock_prev;
    clk_lost = (s.lost_cnt == LOST_LAST) && !tx_line_clock_edge; // see RULE4
    sec_evt = fast_tick && (common_control_two_fast_i || s.fast_cnt == FAST_LAST); // see RULE8
    crc_evt = crc4_enable_i ? ev_i.rx_crc_mf : free_mf_tick; // see RULE5 see RULE6
    rd_alarm = bus_i.rd && bus_i.addr == `FSI_ALARM_STATUS_ADDR;
    rd_timing = bus_i.rd && bus_i.addr == `FSI_TIMING_STATUS_ADDR;
    timing_set = 8'h00;
    timing_set[`FSI_BIT_RX_MF] = ev_i.rx_mf; // see RULE10
    timing_set[`FSI_BIT_RX_AF] = ev_i.rx_af; // see RULE3
    timing_set[`FSI_BIT_TX_MF] = ev_i.tx_mf; // see RULE10
    timing_set[`FSI_BIT_SEC] = sec_evt;
    timing_set[`FSI_BIT_TX_AF] = ev_i.tx_af; // see RULE10
    timing_set[`FSI_BIT_TX_CLK_LOST] = clk_lost;
    timing_set[`FSI_BIT_RX_CRC_MF] = crc_evt;
    timing_set[`FSI_BIT_TX_SLIP] = ev_i.tx_slip; // see RULE7

    next_s = s;
    next_s.tx_line_clock_sync = {s.tx_line_clock_sync[0], tx_line_clock_i};
    next_s.tx_line_clock_prev = s.tx_line_clock_sync[1];
    if (tx_line_clock_edge)
    begin
      next_s.lost_cnt = 8'h00;
    end
    else if (s.lost_cnt != LOST_LAST)
    begin
      next_s.lost_cnt = s.lost_cnt + 8'h01;
    end
    if (fast_tick)
    begin
      next_s.fast_cnt = s.fast_cnt + 4'h1;
    end

    // Clear on read; a set in the same cycle wins
    next_s.timing_status = (rd_timing ? `FSI_STATUS_RESET : s.timing_status) | timing_set;
    next_s.alarm_status = (rd_alarm ? `FSI_STATUS_RESET : s.alarm_status) | alarm_event_i; // see RULE9

    if (bus_i.wr && bus_i.addr == `FSI_ALARM_MASK_ADDR)
    begin
      next_s.alarm_mask = bus_i.wdata;
    end
    if (bus_i.wr && bus_i.addr == `FSI_TIMING_MASK_ADDR)
    begin
      next_s.timing_mask = bus_i.wdata;
    end

    if (bus_i.rd)
    begin
      case (bus_i.addr)
        `FSI_ALARM_STATUS_ADDR: next_s.rdata = s.alarm_status;
        `FSI_TIMING_STATUS_ADDR: next_s.rdata = s.timing_status;
        `FSI_ALARM_MASK_ADDR: next_s.rdata = s.alarm_mask;
        `FSI_TIMING_MASK_ADDR: next_s.rdata = s.timing_mask;
        default: next_s.rdata = 8'h00;
      endcase
    end

    next_s.irq = |(next_s.alarm_status & next_s.alarm_mask) // see RULE1
      | |(next_s.timing_status & next_s.timing_mask); // see RULE2
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rdata;
  assign int_o = s.irq;
  assign counter_update_o = sec_evt;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_quiet_clock;
    !tx_line_clock_edge && s.lost_cnt == LOST_LAST;
  endsequence

  sequence s_both_mf;
    ev_i.rx_mf && ev_i.tx_mf;
  endsequence

  a_alarm_gate_on: assert property ( // see RULE1
    |(s.alarm_status & s.alarm_mask) |-> s.irq)
    else $error("masked-in alarm flag did not raise interrupt");

  a_timing_gate_off: assert property ( // see RULE2
    ((s.timing_status & s.timing_mask) == 8'h00 && (s.alarm_status & s.alarm_mask) == 8'h00)
      |-> !s.irq)
    else $error("interrupt raised with every flag masked");

  a_align_flag: assert property ( // see RULE3
    ev_i.rx_af |=> s.timing_status[`FSI_BIT_RX_AF])
    else $error("align frame flag not set");

  a_clock_lost: assert property ( // see RULE4
    s_quiet_clock |=> s.timing_status[`FSI_BIT_TX_CLK_LOST])
    else $error("clock loss flag not set after one channel time");

  a_lost_restart: assert property ( // see RULE4
    tx_line_clock_edge |=> s.lost_cnt == 8'h00 ##1 !clk_lost)
    else $error("clock edge did not restart the quiet count");

  a_crc_boundary: assert property ( // see RULE5
    crc4_enable_i && ev_i.rx_crc_mf |=> s.timing_status[`FSI_BIT_RX_CRC_MF])
    else $error("crc multiframe flag not set");

  a_crc_free_run: assert property ( // see RULE6
    !crc4_enable_i && free_mf_tick |=> s.timing_status[`FSI_BIT_RX_CRC_MF])
    else $error("free running crc multiframe flag not set");

  a_tx_slip: assert property ( // see RULE7
    ev_i.tx_slip |=> s.timing_status[`FSI_BIT_TX_SLIP])
    else $error("transmit slip flag not set");

  a_sec_slow: assert property ( // see RULE8
    fast_tick && !common_control_two_fast_i && s.fast_cnt != FAST_LAST
      && !rd_timing && !s.timing_status[`FSI_BIT_SEC]
      |=> !s.timing_status[`FSI_BIT_SEC])
    else $error("one second flag set early in slow mode");

  a_sec_fast: assert property ( // see RULE8
    fast_tick && common_control_two_fast_i |=> s.timing_status[`FSI_BIT_SEC])
    else $error("fast timer flag not set");

  a_rx_slip: assert property ( // see RULE9
    alarm_event_i[`FSI_BIT_RX_SLIP] |=> s.alarm_status[`FSI_BIT_RX_SLIP])
    else $error("receive slip flag not set");

  a_mf_flags: assert property ( // see RULE10
    s_both_mf |=> s.timing_status[`FSI_BIT_RX_MF] && s.timing_status[`FSI_BIT_TX_MF])
    else $error("multiframe flags not set");

  a_alarm_mask_wr: assert property ( // see RULE1
    bus_i.wr && bus_i.addr == `FSI_ALARM_MASK_ADDR |=> s.alarm_mask == $past(bus_i.wdata))
    else $error("alarm mask write not stored");

  a_timing_mask_wr: assert property ( // see RULE2
    bus_i.wr && bus_i.addr == `FSI_TIMING_MASK_ADDR |=> s.timing_mask == $past(bus_i.wdata))
    else $error("timing mask write not stored");

  a_alarm_read_clear: assert property ( // see RULE9
    rd_alarm && alarm_event_i == 8'h00 |=> s.alarm_status == 8'h00)
    else $error("alarm flags not cleared by read");

endmodule // fsi_status_irq

/* File: verif/fsi_host_model.sv */
`timescale 1ns/1ps
module fsi_host_model
  import fsi_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Parallel control port
  output fsi_bus_s bus_o,
  input wire logic [7:0] rdata_i
);
  initial bus_o = '0;

  task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    bus_o <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus_o.wr <= 1'b0;
  endtask

  // Data is taken once the strobe edge has updated it
  task automatic read_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    bus_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus_o.rd <= 1'b0;
    #1 v = rdata_i;
  endtask
endmodule // fsi_host_model

/* File: verif/fsi_status_irq_tb.sv */
`timescale 1ns/1ps
`include "fsi_defs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module fsi_status_irq_tb
  import fsi_pkg::*;
;
  logic clk_i, resetn_i, crc4_en, fast, tx_line_clock_run, int_o, cu;
  logic tx_line_clock = 1'b0;
  fsi_bus_s bus;
  fsi_events_s ev;
  logic [7:0] alarm_ev, rdata, d;
  logic [7:0] pos [6] = '{8'h01, 8'h02, 8'h08, 8'h20, 8'h40, 8'h80};
  int n_tests, miscompares;
  int cyc = 0;
  integer k;

  fsi_host_model u_fsi_host_model (.clk_i(clk_i), .bus_o(bus), .rdata_i(rdata));
  fsi_status_irq #(.FAST_CYCLES(64), .CRC_MF_CYCLES(50)) u_fsi_status_irq (
    .clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus), .rdata_o(rdata), .ev_i(ev),
    .alarm_event_i(alarm_ev), .crc4_enable_i(crc4_en),
    .common_control_two_fast_i(fast), .tx_line_clock_i(tx_line_clock), .int_o(int_o),
    .counter_update_o(cu));

  initial
  begin
    clk_i = 0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Transmit line clock and run limit
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (tx_line_clock_run && cyc[1:0] == 2'h0)
      tx_line_clock <= ~tx_line_clock;
    if (cyc == 30000)
    begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic rd(input logic [7:0] a);
    u_fsi_host_model.read_reg(a, d);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_fsi_host_model.write_reg(a, v);
    @(posedge clk_i);
    #1;
  endtask

  task automatic pulse(input logic [5:0] e, input logic [7:0] a);
    @(posedge clk_i);
    ev <= e;
    alarm_ev <= a;
    @(posedge clk_i);
    ev <= '0;
    alarm_ev <= '0;
    @(posedge clk_i);
    #1;
  endtask

  // Counts update pulses over n cycles
  task automatic count(input int n);
    k = 0;
    repeat (n)
    begin
      @(negedge clk_i);
      k += cu;
    end
  endtask

  initial
  begin
    resetn_i = 0; crc4_en = 1; fast = 0; tx_line_clock_run = 1;
    ev = '0; alarm_ev = 8'h00; n_tests = 0; miscompares = 0;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1;
    rd(`FSI_ALARM_MASK_ADDR);
    `CHK("mask1 reset", 8'h00, d)
    rd(`FSI_TIMING_MASK_ADDR);
    `CHK("mask2 reset", 8'h00, d)
    wr(`FSI_ALARM_MASK_ADDR, 8'ha5);
    rd(`FSI_ALARM_MASK_ADDR);
    `CHK("mask1 rw", 8'ha5, d)
    rd(8'h20);
    `CHK("unmapped", 8'h00, d)
    foreach (pos[i])
    begin
      wr(`FSI_TIMING_MASK_ADDR, 8'hef & ~pos[i]);
      rd(`FSI_TIMING_STATUS_ADDR);
      pulse(6'(1 << i), 8'h00);
      `CHK("int masked", 1'b0, int_o)
      wr(`FSI_TIMING_MASK_ADDR, pos[i]);
      `CHK("int enabled", 1'b1, int_o)
      rd(`FSI_TIMING_STATUS_ADDR);
      `CHK("event flag", pos[i], d & pos[i])
    end
    // Both multiframe events in one cycle
    pulse(6'h28, 8'h00);
    rd(`FSI_TIMING_STATUS_ADDR);
    `CHK("both mf", 8'ha0, d & 8'ha0)
    wr(`FSI_TIMING_MASK_ADDR, 8'h00);
    wr(`FSI_ALARM_MASK_ADDR, 8'hef);
    pulse(6'h00, 8'h10);
    `CHK("slip masked", 1'b0, int_o)
    wr(`FSI_ALARM_MASK_ADDR, 8'h10);
    `CHK("slip int", 1'b1, int_o)
    rd(`FSI_ALARM_STATUS_ADDR);
    `CHK("rx slip", 8'h10, d)
    wr(`FSI_ALARM_MASK_ADDR, 8'h00);
    wr(`FSI_TIMING_MASK_ADDR, 8'h04);
    rd(`FSI_TIMING_STATUS_ADDR);
    tx_line_clock_run <= 1'b0;
    repeat (140) @(posedge clk_i);
    #1;
    `CHK("clk lost early", 1'b0, int_o)
    repeat (30) @(posedge clk_i);
    #1;
    `CHK("clk lost int", 1'b1, int_o)
    tx_line_clock_run <= 1'b1;
    repeat (10) @(posedge clk_i);
    rd(`FSI_TIMING_STATUS_ADDR);
    `CHK("clk lost flag", 8'h04, d & 8'h04)
    repeat (100) @(posedge clk_i);
    rd(`FSI_TIMING_STATUS_ADDR);
    `CHK("clk back", 8'h00, d & 8'h04)
    wr(`FSI_TIMING_MASK_ADDR, 8'h10);
    @(posedge clk_i);
    fast <= 1'b1;
    count(256);
    `CHK("fast ticks", 4, k)
    `CHK("sec int", 1'b1, int_o)
    rd(`FSI_TIMING_STATUS_ADDR);
    `CHK("sec flag", 8'h10, d & 8'h10)
    @(posedge clk_i);
    fast <= 1'b0;
    count(2048);
    `CHK("slow ticks", 2, k)
    wr(`FSI_TIMING_MASK_ADDR, 8'h00);
    @(posedge clk_i);
    crc4_en <= 0;
    rd(`FSI_TIMING_STATUS_ADDR);
    repeat (52) @(posedge clk_i);
    rd(`FSI_TIMING_STATUS_ADDR);
    `CHK("crc free", 8'h02, d & 8'h02)
    repeat (20) @(posedge clk_i);
    rd(`FSI_TIMING_STATUS_ADDR);
    `CHK("crc gap", 8'h00, d & 8'h02)
    repeat (30) @(posedge clk_i);
    rd(`FSI_TIMING_STATUS_ADDR);
    `CHK("crc period", 8'h02, d & 8'h02)
    summarize();
  end
endmodule // fsi_status_irq_tb
